// ===== rtl/mcr_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Power bit 0 switches whole chip on.
// - Power bit 1 enables temperature sensor.
// - Power bit 2 enables current amplifier.
// - Power bit 3 enables voltage amplifier.
// - Power bit 4 enables converter reference.
// - Power bit 5 enables overcurrent detector.
// - Power bit 6 picks overcurrent input pair.
// - Current gain equals twice code plus two.
// - Voltage gain equals twice code plus two.
// - Three-bit select picks converter input; 6,7 reserved.
// - Arm bit starts conversion at next select fall.
// - Overtemperature when temperature exceeds limit register.
// - Enable bits gate each alarm source.
// - Power control resets to all zeros.
// - Any event raises the common warning flag.
// - Captured events hold until status is read.

// Link-side shifter; frame state is cleared while the select is high.
module mcr_link (
  input  wire logic               sclk_i,
  input  wire logic               serial_select_n_i,
  input  wire logic               mosi_i,
  input  wire mcr_pkg::mcr_regs_t regs_i,
  output logic                    miso_o,
  output logic                    miso_oe_o,
  output mcr_pkg::mcr_req_t       req_o
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic       miso;
    logic       oe;
    mcr_req_t   req;
  } mcr_link_t;

  mcr_link_t r;
  mcr_link_t next_r;

  function automatic logic [7:0] read_mux(input mcr_regs_t g, input logic [6:0] a);
    logic [7:0] v;
    v = ZERO_BYTE;
    unique case (a)
      ADDR_POWER:    v = g.power;
      ADDR_GAIN:     v = g.gain;
      ADDR_INSEL:    v = g.insel;
      ADDR_TLIMIT:   v = g.tlimit;
      ADDR_ALARM_EN: v = g.alarm_en;
      ADDR_STATUS:   v = g.status;
      default:       v = ZERO_BYTE;
    endcase
    return v;
  endfunction : read_mux

  always_comb begin
    logic [7:0] out_byte;
    out_byte = ZERO_BYTE;
    next_r = r;
    next_r.oe = 1'b1;
    next_r.shift = {r.shift[6:0], mosi_i};
    if (r.cnt != CNT_END) begin
      next_r.cnt = r.cnt + CNT_ONE;
    end
    if (r.cnt == CNT_ADDR_LAST) begin
      // The first read bit must be on the line before the next rising edge.
      out_byte = read_mux(regs_i, next_r.shift[6:0]);
      next_r.req.read = next_r.shift[7];
      next_r.req.addr = next_r.shift[6:0];
      next_r.miso = out_byte[7];
      next_r.tx = {out_byte[6:0], 1'b0};
    end else if (r.cnt > CNT_ADDR_LAST && r.cnt < CNT_DATA_LAST) begin
      next_r.miso = r.tx[7];
      next_r.tx = {r.tx[6:0], 1'b0};
    end
    if (r.cnt == CNT_DATA_LAST) begin
      next_r.req.data = next_r.shift;
      next_r.req.done = 1'b1;
    end
  end

  always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
    if (serial_select_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign miso_o    = r.miso;
  assign miso_oe_o = r.oe;
  assign req_o     = r.req;

endmodule : mcr_link

module mcr_top (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       sclk_i,
  input  wire logic       serial_select_n_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  input  wire logic [7:0] temp_value_i,
  input  wire logic       undervoltage_event_i,
  input  wire logic       overcurrent_event_i,
  output logic            chip_enable_o,
  output logic            temp_sensor_enable_o,
  output logic            current_amp_enable_o,
  output logic            voltage_amp_enable_o,
  output logic            converter_ref_enable_o,
  output logic            overcurrent_enable_o,
  output logic            overcurrent_secondary_o,
  output logic [6:0]      current_gain_o,
  output logic [3:0]      voltage_gain_o,
  output mcr_pkg::mcr_input_t converter_input_o,
  output logic            conversion_start_o,
  output logic            overtemp_o,
  output logic            warning_o,
  output logic            alarm_o
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [7:0]       power;
    logic [7:0]       gain;
    logic [7:0]       insel;
    logic [7:0]       tlimit;
    logic [7:0]       alarm_en;
    logic [SRC_N-1:0] status;
    logic [2:0]       sel_sync;
    logic             sel_lvl;
    logic [2:0]       done_sync;
    logic             done_lvl;
    logic [6:0]       curr_gain;
    logic [3:0]       volt_gain;
    logic             conv_start;
    logic             overtemp;
    logic             warning;
    logic             alarm;
  } mcr_core_t;

  localparam mcr_core_t CORE_RST = '{
    power:     RST_POWER,
    gain:      RST_GAIN,
    insel:     RST_INSEL,
    tlimit:    RST_TLIMIT,
    alarm_en:  RST_ALARM_EN,
    status:    '0,
    sel_sync:  3'h7,
    sel_lvl:   1'b1,
    done_sync: 3'h0,
    done_lvl:  1'b0,
    curr_gain: {1'b0, GAIN_BASE},
    volt_gain: GAIN_BASE[3:0],
    conv_start: 1'b0,
    overtemp:  1'b0,
    warning:   1'b0,
    alarm:     1'b0
  };

  mcr_core_t r;
  mcr_core_t next_r;
  mcr_req_t  req;
  mcr_regs_t regs;
  logic      sel_fall;
  logic      frame_done;
  logic [SRC_N-1:0] events;

  // Configuration words change only after a completed frame, or for the arm bit just
  // after a select fall, so the link reads them while they stand still.
  assign regs = '{
    power:    r.power,
    gain:     r.gain,
    insel:    r.insel,
    tlimit:   r.tlimit,
    alarm_en: r.alarm_en,
    status:   {{(DATA_W-SRC_N){1'b0}}, r.status}
  };

  mcr_link u_link (
    .sclk_i            (sclk_i),
    .serial_select_n_i (serial_select_n_i),
    .mosi_i            (mosi_i),
    .regs_i            (regs),
    .miso_o            (miso_o),
    .miso_oe_o         (miso_oe_o),
    .req_o             (req)
  );

  always_comb begin
    next_r = r;
    sel_fall = 1'b0;
    frame_done = 1'b0;
    events = '0;

    // Three-stage capture; a change is taken once stages two and three agree.
    next_r.sel_sync = {r.sel_sync[1:0], serial_select_n_i};
    if (r.sel_sync[1] == r.sel_sync[2]) begin
      next_r.sel_lvl = r.sel_sync[2];
    end
    sel_fall = r.sel_lvl & ~next_r.sel_lvl;
    next_r.done_sync = {r.done_sync[1:0], req.done};
    if (r.done_sync[1] == r.done_sync[2]) begin
      next_r.done_lvl = r.done_sync[2];
    end
    frame_done = ~r.done_lvl & next_r.done_lvl;

    if (frame_done && !req.read) begin
      unique case (req.addr)
        ADDR_POWER:    next_r.power = req.data & MASK_POWER;
        ADDR_GAIN:     next_r.gain = req.data & MASK_GAIN;
        ADDR_INSEL:    next_r.insel = req.data & MASK_INSEL;
        ADDR_TLIMIT:   next_r.tlimit = req.data & MASK_TLIMIT;
        ADDR_ALARM_EN: next_r.alarm_en = req.data & MASK_ALARM_EN;
        default:       next_r.power = r.power;
      endcase
    end

    // One conversion per arming; the arm bit drops when it starts.
    next_r.conv_start = 1'b0;
    if (sel_fall && r.insel[INSEL_ARM]) begin
      next_r.conv_start = 1'b1;
      next_r.insel[INSEL_ARM] = 1'b0;
    end

    next_r.overtemp = temp_value_i > r.tlimit;
    events[SRC_OVERTEMP] = next_r.overtemp;
    events[SRC_UNDERVOLT] = undervoltage_event_i;
    events[SRC_OVERCURR] = overcurrent_event_i;

    // A read of the status word clears it, but a new event still lands.
    if (frame_done && req.read && req.addr == ADDR_STATUS) begin
      next_r.status = events;
    end else begin
      next_r.status = r.status | events;
    end
    next_r.warning = |next_r.status;
    next_r.alarm = |(next_r.status & next_r.alarm_en[SRC_N-1:0]);

    // The largest code gives a gain of 64, which needs a seventh bit.
    next_r.curr_gain = {1'b0, GAIN_STEP} * {2'b00, next_r.gain[GAIN_CURR_MSB:GAIN_CURR_LSB]}
                       + {1'b0, GAIN_BASE};
    next_r.volt_gain = 4'(GAIN_STEP * {4'h0, next_r.gain[GAIN_VOLT_MSB:GAIN_VOLT_LSB]}
                       + GAIN_BASE);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign chip_enable_o           = r.power[PWR_CHIP];
  assign temp_sensor_enable_o    = r.power[PWR_TEMP];
  assign current_amp_enable_o    = r.power[PWR_CURR_AMP];
  assign voltage_amp_enable_o    = r.power[PWR_VOLT_AMP];
  assign converter_ref_enable_o  = r.power[PWR_REF];
  assign overcurrent_enable_o    = r.power[PWR_OC_EN];
  assign overcurrent_secondary_o = r.power[PWR_OC_SEC];
  assign current_gain_o          = r.curr_gain;
  assign voltage_gain_o          = r.volt_gain;
  assign converter_input_o       = mcr_input_t'(r.insel[INSEL_SEL_MSB:INSEL_SEL_LSB]);
  assign conversion_start_o      = r.conv_start;
  assign overtemp_o              = r.overtemp;
  assign warning_o               = r.warning;
  assign alarm_o                 = r.alarm;

endmodule : mcr_top

// ===== rtl/mcr_pkg.sv
package mcr_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register byte addresses.
  localparam logic [6:0] ADDR_POWER    = 7'h01;
  localparam logic [6:0] ADDR_GAIN     = 7'h02;
  localparam logic [6:0] ADDR_INSEL    = 7'h03;
  localparam logic [6:0] ADDR_TLIMIT   = 7'h04;
  localparam logic [6:0] ADDR_ALARM_EN = 7'h05;
  localparam logic [6:0] ADDR_STATUS   = 7'h17;

  // Reset values.
  localparam logic [7:0] RST_POWER    = 8'h00;
  localparam logic [7:0] RST_GAIN     = 8'h00;
  localparam logic [7:0] RST_INSEL    = 8'h00;
  localparam logic [7:0] RST_TLIMIT   = 8'hff;
  localparam logic [7:0] RST_ALARM_EN = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Implemented bits of each register; all other bits are dropped on write.
  localparam logic [7:0] MASK_POWER    = 8'h7f;
  localparam logic [7:0] MASK_GAIN     = 8'hdf;
  localparam logic [7:0] MASK_INSEL    = 8'h17;
  localparam logic [7:0] MASK_TLIMIT   = 8'hff;
  localparam logic [7:0] MASK_ALARM_EN = 8'h07;

  // Power control bits.
  localparam int unsigned PWR_CHIP     = 0;
  localparam int unsigned PWR_TEMP     = 1;
  localparam int unsigned PWR_CURR_AMP = 2;
  localparam int unsigned PWR_VOLT_AMP = 3;
  localparam int unsigned PWR_REF      = 4;
  localparam int unsigned PWR_OC_EN    = 5;
  localparam int unsigned PWR_OC_SEC   = 6;

  // Gain fields.
  localparam int unsigned GAIN_CURR_LSB = 0;
  localparam int unsigned GAIN_CURR_MSB = 4;
  localparam int unsigned GAIN_VOLT_LSB = 6;
  localparam int unsigned GAIN_VOLT_MSB = 7;

  // Input select fields.
  localparam int unsigned INSEL_SEL_LSB = 0;
  localparam int unsigned INSEL_SEL_MSB = 2;
  localparam int unsigned INSEL_ARM     = 4;

  // Alarm source bits, shared by the enable and the status register.
  localparam int unsigned SRC_OVERTEMP  = 0;
  localparam int unsigned SRC_UNDERVOLT = 1;
  localparam int unsigned SRC_OVERCURR  = 2;
  localparam int unsigned SRC_N         = 3;

  typedef enum logic [2:0] {
    MCR_IN_CURR_AMP = 3'b000,
    MCR_IN_VOLT_AMP = 3'b001,
    MCR_IN_SECOND   = 3'b010,
    MCR_IN_SUPPLY   = 3'b011,
    MCR_IN_MAIN     = 3'b100,
    MCR_IN_FIRST    = 3'b101,
    MCR_IN_RSVD6    = 3'b110,
    MCR_IN_RSVD7    = 3'b111
  } mcr_input_t;

  // Link frame bit counts.
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0] CNT_END       = 5'h10;
  localparam logic [4:0] CNT_ONE       = 5'h01;

  // Multiplier and offset of the gain formula.
  localparam logic [5:0] GAIN_STEP = 6'h02;
  localparam logic [5:0] GAIN_BASE = 6'h02;

  // Register images read back over the link.
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] gain;
    logic [7:0] insel;
    logic [7:0] tlimit;
    logic [7:0] alarm_en;
    logic [7:0] status;
  } mcr_regs_t;

  // One finished frame handed from the link to the core.
  typedef struct packed {
    logic       done;
    logic       read;
    logic [6:0] addr;
    logic [7:0] data;
  } mcr_req_t;

endpackage : mcr_pkg

// ===== dv/mcr_properties.sv
`timescale 1ns/1ns
module mcr_properties (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       serial_select_n_i,
  input wire logic [7:0] temp_value_i,
  input wire logic       overcurrent_event_i,
  input wire logic       chip_enable_o,
  input wire logic [6:0] current_gain_o,
  input wire logic [3:0] voltage_gain_o,
  input wire logic       conversion_start_o,
  input wire logic       overtemp_o,
  input wire logic       warning_o,
  input wire logic       alarm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence sel_idle; serial_select_n_i [*6]; endsequence
  sequence link_quiet; serial_select_n_i [*8]; endsequence
  a_reset_state: assert property ($past(reset_i) |-> !chip_enable_o && current_gain_o == 7'h02)
    else $error("Power state wrong after reset.");
  a_cgain_even: assert property (!current_gain_o[0] && current_gain_o != 7'h00)
    else $error("Current gain not an even value of two or more.");
  a_vgain_set: assert property (voltage_gain_o inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("Voltage gain outside its four values.");
  a_start_pulse: assert property (conversion_start_o |=> !conversion_start_o)
    else $error("Conversion start longer than one cycle.");
  a_start_cause: assert property (sel_idle |-> !conversion_start_o)
    else $error("Conversion start without a select fall.");
  a_temp_bounds: assert property (temp_value_i == 8'h00 |=> !overtemp_o)
    else $error("Overtemperature flagged for the lowest value.");
  a_warn_event: assert property (overcurrent_event_i |-> ##[1:3] warning_o)
    else $error("Warning missing after an overcurrent event.");
  a_warn_temp: assert property (overtemp_o |-> ##[0:3] warning_o)
    else $error("Warning missing after overtemperature.");
  a_warn_hold: assert property (link_quiet ##0 warning_o |=> warning_o)
    else $error("Warning dropped without a status read.");
  a_alarm_gate: assert property (alarm_o |-> warning_o)
    else $error("Alarm without a captured event.");
endmodule : mcr_properties

bind mcr_top mcr_properties chk (.clk_i(clk_i), .reset_i(reset_i),
  .serial_select_n_i(serial_select_n_i), .temp_value_i(temp_value_i),
  .overcurrent_event_i(overcurrent_event_i), .chip_enable_o(chip_enable_o),
  .current_gain_o(current_gain_o), .voltage_gain_o(voltage_gain_o),
  .conversion_start_o(conversion_start_o), .overtemp_o(overtemp_o),
  .warning_o(warning_o), .alarm_o(alarm_o));

// ===== dv/mcr_host_model.sv
`timescale 1ns/1ns
module mcr_host_model (
  output logic      sclk_o,
  output logic      select_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Each call is one frame, so every frame opens with a fresh select fall.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    #7 select_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = tx[i];
      #62 sclk_o = 1'b1;
      if (i < 8) rx = {rx[6:0], miso_i};
      #63 sclk_o = 1'b0;
    end
    #63 select_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #70;
  endtask : xfer
endmodule : mcr_host_model

// ===== dv/tb_measurement_config_registers.sv
`timescale 1ns/1ns
module tb_measurement_config_registers;
  import mcr_pkg::*;
  logic       clk_i = 1'b0, reset_i = 1'b1, und_ev = 1'b0, oc_ev = 1'b0;
  logic       sclk, sel_n, mosi, miso, cstart, ot, warn, alarm, oe;
  logic [7:0] temp = 8'h00, r, d;
  logic [6:0] a;
  logic [6:0] cg;
  logic [3:0] vg;
  wire  [6:0] pwr;
  mcr_input_t mux;
  int         n_errors = 0, check_count = 0, n_start = 0, s0;
  mcr_host_model host (.sclk_o(sclk), .select_n_o(sel_n), .mosi_o(mosi), .miso_i(miso));
  mcr_top dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .serial_select_n_i(sel_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe), .temp_value_i(temp),
    .undervoltage_event_i(und_ev), .overcurrent_event_i(oc_ev), .chip_enable_o(pwr[0]),
    .temp_sensor_enable_o(pwr[1]), .current_amp_enable_o(pwr[2]),
    .voltage_amp_enable_o(pwr[3]), .converter_ref_enable_o(pwr[4]),
    .overcurrent_enable_o(pwr[5]), .overcurrent_secondary_o(pwr[6]), .current_gain_o(cg),
    .voltage_gain_o(vg), .converter_input_o(mux), .conversion_start_o(cstart),
    .overtemp_o(ot), .warning_o(warn), .alarm_o(alarm));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (cstart === 1'b1) n_start++;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xf(input logic [7:0] c, input logic [7:0] w);
    host.xfer({c, w}, r);
    repeat (8) @(posedge clk_i);
  endtask : xf
  task automatic pulse(input logic u, input logic o);
    @(posedge clk_i);
    und_ev <= u;
    oc_ev <= o;
    @(posedge clk_i);
    und_ev <= 1'b0;
    oc_ev <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  function automatic logic [7:0] mask_of(input logic [6:0] x);
    case (x)
      ADDR_POWER: return MASK_POWER;
      ADDR_GAIN: return MASK_GAIN;
      ADDR_INSEL: return MASK_INSEL;
      ADDR_TLIMIT: return MASK_TLIMIT;
      ADDR_ALARM_EN: return MASK_ALARM_EN;
      default: return 8'h00;
    endcase
  endfunction : mask_of
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(8));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("gain_rst", {1'b0, cg}, 8'h02);
    check("oe_idle", {7'h00, oe}, 8'h00);
    check("pwr_rst", {1'b0, pwr}, RST_POWER);
    for (int i = 0; i < 7; i++) begin
      xf({1'b1, 7'(i)}, 8'h00);
      check("reg_rst", r, (7'(i) == ADDR_TLIMIT) ? RST_TLIMIT : 8'h00);
    end
    for (int i = 0; i < 14; i++) begin
      a = 7'($urandom_range(1, 6));
      d = 8'($urandom) & ((a == ADDR_INSEL) ? 8'hef : 8'hff);
      if (i == 0) {a, d} = {ADDR_GAIN, 8'hdf};
      if (i == 1) {a, d} = {ADDR_POWER, 8'hff};
      xf({1'b0, a}, d);
      xf({1'b1, a}, 8'h00);
      check("reg_rw", r, d & mask_of(a));
      if (a == ADDR_POWER) check("pwr", {1'b0, pwr}, d & 8'h7f);
      if (a == ADDR_GAIN) begin
        check("cgain", {1'b0, cg}, {2'b00, d[4:0], 1'b0} + 8'h02);
        check("vgain", {4'h0, vg}, {5'h00, d[7:6], 1'b0} + 8'h02);
      end
    end
    xf({1'b0, ADDR_POWER}, 8'h11);
    for (int c = 0; c < 6; c++) begin
      s0 = n_start;
      xf({1'b0, ADDR_INSEL}, 8'h10 | 8'(c));
      check("mux", {5'h00, mux}, 8'(c));
      check("no_start", 8'(n_start - s0), 8'h00);
      xf({1'b1, ADDR_INSEL}, 8'h00);
      check("start", 8'(n_start - s0), 8'h01);
      check("arm_clr", r, 8'(c));
    end
    xf({1'b0, ADDR_ALARM_EN}, 8'h00);
    pulse(1'b1, 1'b0);
    check("warn_uv", {7'h00, warn}, 8'h01);
    check("alarm_off", {7'h00, alarm}, 8'h00);
    xf({1'b0, ADDR_ALARM_EN}, 8'h02);
    check("alarm_on", {7'h00, alarm}, 8'h01);
    xf({1'b1, ADDR_STATUS}, 8'h00);
    check("stat_uv", r, 8'h02);
    xf({1'b1, ADDR_STATUS}, 8'h00);
    check("stat_clr", {r[7:1], warn}, 8'h00);
    pulse(1'b0, 1'b1);
    check("alarm_mask", {6'h00, alarm, warn}, 8'h01);
    xf({1'b1, ADDR_STATUS}, 8'h00);
    check("stat_oc", r, 8'h04);
    xf({1'b0, ADDR_ALARM_EN}, 8'h01);
    d = 8'($urandom_range(1, 254));
    xf({1'b0, ADDR_TLIMIT}, d);
    temp <= d;
    repeat (4) @(posedge clk_i);
    check("ot_equal", {7'h00, ot}, 8'h00);
    temp <= d + 8'h01;
    repeat (4) @(posedge clk_i);
    check("ot_above", {5'h00, ot, warn, alarm}, 8'h07);
    temp <= 8'h00;
    repeat (4) @(posedge clk_i);
    xf({1'b1, ADDR_STATUS}, 8'h00);
    check("stat_ot", r, 8'h01);
    report_and_stop();
  end
endmodule : tb_measurement_config_registers
